// >>> verilog/cssi_map.vh
// Constants for the configuration scheme select and flash access block.
// Included by the top-level design file of the block only.
`ifndef CSSI_MAP_VH
`define CSSI_MAP_VH

// Register byte offsets
`define CSSI_CTRL_OFF    12'h000
`define CSSI_STATUS_OFF  12'h004
`define CSSI_WORDS_OFF   12'h008

// Control fields
`define CSSI_CTRL_RUPD   0
`define CSSI_CTRL_BRIDGE 1
`define CSSI_CTRL_RESET  32'h00000000
`define CSSI_WORDS_RESET 24'h000100

// Status fields
`define CSSI_ST_SCHEME_LSB 0
`define CSSI_ST_STATE_LSB  4
`define CSSI_ST_UNSUP      7
`define CSSI_ST_FASTPOR    8
`define CSSI_ST_VOLT_LSB   9
`define CSSI_ST_CE         11
`define CSSI_ST_FULL       12

// Scheme select codes
`define CSSI_SEL_FAST_33  4'h5
`define CSSI_SEL_FAST_18  4'h6
`define CSSI_SEL_STD_33   4'h7
`define CSSI_SEL_STD_18   4'h8
`define CSSI_SEL_STD_30   4'hB

// Voltage codes
`define CSSI_V33 2'h0
`define CSSI_V18 2'h1
`define CSSI_V30 2'h2

// Timing: oscillator limit and divider ratio (rounded up, never faster)
`define CSSI_OSC_MHZ  40
`define CSSI_PCLK_MHZ 100
`define CSSI_DIV ((`CSSI_PCLK_MHZ + `CSSI_OSC_MHZ - 1) / `CSSI_OSC_MHZ)

`endif

// >>> verilog/cssi_clkdiv.v
// Configuration clock divider: derives the flash clock from pclk.
// Assumes pclk at the rate in the map header.
`timescale 1ns/1ps
`default_nettype none
module cssi_clkdiv #(
   parameter integer DIV = 3
) (
   input wire pclk, // System clock
   input wire presetn, // Async reset, low
   input wire run, // Divider runs while high
   output reg clk_q, // Divided clock
   output reg rise_q, // Pulse: clock just rose
   output reg fall_q // Pulse: clock just fell
);
   reg [3:0] cnt_q;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 4'h0;
         clk_q <= 1'b0;
         rise_q <= 1'b0;
         fall_q <= 1'b0;
      end else if (!run) begin
         cnt_q <= 4'h0;
         clk_q <= 1'b0;
         rise_q <= 1'b0;
         fall_q <= clk_q;
      end else begin
         cnt_q <= (cnt_q == DIV[3:0] - 4'h1) ? 4'h0 : cnt_q + 4'h1;
         rise_q <= (cnt_q == 4'h0);
         fall_q <= (cnt_q == 4'h1);
         if (cnt_q == 4'h0)
            clk_q <= 1'b1;
         else if (cnt_q == 4'h1)
            clk_q <= 1'b0;
      end
   end
endmodule // cssi_clkdiv
`default_nettype wire

// >>> verilog/cssi_fifo.v
// Word FIFO with registered output stage.
// Assumes one clock; clr empties it at once.
`timescale 1ns/1ps
`default_nettype none
module cssi_fifo #(
   parameter integer WIDTH = 16,
   parameter integer DEPTH = 8,
   parameter integer AW = 3
) (
   input wire pclk, // System clock
   input wire presetn, // Async reset, low
   input wire clr, // Synchronous flush
   input wire in_valid, // Write request
   input wire [WIDTH-1:0] in_data, // Write data
   output wire in_ready, // Room left
   output reg out_valid_q, // Output word valid
   output reg [WIDTH-1:0] out_data_q, // Output word
   input wire out_ready, // Consumer takes word
   output wire full // No room
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_q;
   reg [AW-1:0] rd_q;
   reg [AW:0] cnt_q;
   wire push;
   wire pop;
   assign full = (cnt_q == DEPTH[AW:0]);
   assign in_ready = ~full;
   assign push = in_valid & ~full;
   assign pop = (cnt_q != {(AW+1){1'b0}}) & (~out_valid_q | out_ready);

   always @(posedge pclk) begin
      if (push)
         mem[wr_q] <= in_data;
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_q <= {AW{1'b0}};
         rd_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
         out_valid_q <= 1'b0;
         out_data_q <= {WIDTH{1'b0}};
      end else if (clr) begin
         wr_q <= {AW{1'b0}};
         rd_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
         out_valid_q <= 1'b0;
      end else begin
         if (push)
            wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
         if (pop) begin
            rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
            out_data_q <= mem[rd_q];
            out_valid_q <= 1'b1;
         end else if (out_ready)
            out_valid_q <= 1'b0;
         cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
endmodule // cssi_fifo
`default_nettype wire

// >>> verilog/cssi_top.v
// Configuration scheme select, parallel flash loader and JTAG-to-serial bridge.
// Assumes pins synchronous to pclk and an APB master for the registers.
//
// Summary of operation
// - Start input low holds loader in reset
// - Parallel scheme fetches 16-bit words into cells
// - Device masters parallel interface and clock
// - Decode five parallel scheme select codes
// - Parallel schemes offer optional remote update
// - Small variants lack top select bit
// - JTAG bytes forwarded to serial flash
// - Flash select is serial chip select; data1 command
// - Serial link clocked by divided configuration clock
// - Parallel clock never exceeds oscillator rate
`timescale 1ns/1ps
`default_nettype none
`include "cssi_map.vh"
module cssi_top #(
   parameter AP_SUPPORTED = 1'b1
) (
   input wire pclk, // System clock
   input wire presetn, // Async reset, low
   input wire psel, // APB select
   input wire penable, // APB enable
   input wire pwrite, // APB direction
   input wire [11:0] paddr, // APB address
   input wire [31:0] pwdata, // APB write data
   output reg [31:0] prdata, // APB read data
   output reg pready, // APB ready
   output reg pslverr, // APB error
   input wire [3:0] scheme_select, // Scheme select straps
   input wire config_start_n, // Configuration start, low holds reset
   input wire chip_enable_in_n, // Chip enable input
   output reg chain_enable_out_n, // Chain enable out
   output wire config_clock_out, // Configuration clock
   output reg config_clock_oe, // Clock drive enable
   output reg flash_select_out_n, // Flash select / serial chip select
   output reg flash_select_oe, // Select drive enable
   output reg serial_cmd_out, // Serial command data
   output reg serial_cmd_oe, // Serial data drive enable
   output reg [23:0] flash_addr, // Parallel flash address
   output reg flash_oe_n, // Parallel flash output enable
   output reg flash_bus_oe, // Address/control drive enable
   input wire [15:0] flash_data_in, // Parallel flash data
   input wire jtag_byte_valid, // JTAG bridge byte offered
   input wire [7:0] jtag_byte, // JTAG bridge byte
   output reg jtag_byte_ready, // Pulse: byte taken
   output wire cell_wvalid, // Configuration cell write valid
   output wire [15:0] cell_wdata, // Configuration cell data
   input wire cell_wready, // Cell array accepts word
   output reg config_done, // Loading finished
   output reg config_error, // Unsupported scheme
   output reg fast_por, // Fast power-on-reset chosen
   output reg remote_update_on // Remote update active
);
   localparam [2:0] ST_RESET = 3'd0;
   localparam [2:0] ST_DECODE = 3'd1;
   localparam [2:0] ST_LOAD = 3'd2;
   localparam [2:0] ST_DRAIN = 3'd3;
   localparam [2:0] ST_USER = 3'd4;
   localparam [2:0] ST_UNSUP = 3'd5;
   localparam [2:0] ST_BRIDGE = 3'd6;

   reg [2:0] state_q;
   reg [3:0] scheme_q;
   reg [1:0] volt_q;
   reg is_ap_q;
   reg fast_q;
   reg [31:0] ctrl_q;
   reg [23:0] words_q;
   reg [23:0] fetched_q;
   reg [23:0] wrote_q;
   reg [7:0] shift_q;
   reg [3:0] bits_q;
   reg push_q;
   reg [15:0] push_data_q;
   wire fifo_ready;
   wire fifo_full;
   wire div_run;
   wire clk_rise;
   wire clk_fall;
   wire [3:0] sel_eff;
   wire bridge_live;
   wire apb_wr;
   reg dec_ap;
   reg dec_fast;
   reg [1:0] dec_volt;

   ////////////////////////////////////////////////////////////////////////
   // Scheme decode
   assign sel_eff = AP_SUPPORTED ? scheme_select : {1'b0, scheme_select[2:0]};

   always @* begin
      dec_ap = 1'b1;
      dec_fast = 1'b0;
      dec_volt = `CSSI_V33;
      case (sel_eff)
         `CSSI_SEL_FAST_33: begin
            dec_fast = 1'b1;
         end
         `CSSI_SEL_FAST_18: begin
            dec_fast = 1'b1;
            dec_volt = `CSSI_V18;
         end
         `CSSI_SEL_STD_33: begin
            dec_volt = `CSSI_V33;
         end
         `CSSI_SEL_STD_18: begin
            dec_volt = `CSSI_V18;
         end
         `CSSI_SEL_STD_30: begin
            dec_volt = `CSSI_V30;
         end
         default: begin
            dec_ap = 1'b0;
         end
      endcase
      if (!AP_SUPPORTED)
         dec_ap = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Configuration clock
   assign div_run = (state_q == ST_LOAD) || bridge_live;
   assign bridge_live = (state_q == ST_BRIDGE) && !chip_enable_in_n;

   cssi_clkdiv #(
      .DIV(`CSSI_DIV)
   ) u_div (
      .pclk(pclk),
      .presetn(presetn),
      .run(div_run),
      .clk_q(config_clock_out),
      .rise_q(clk_rise),
      .fall_q(clk_fall)
   );

   ////////////////////////////////////////////////////////////////////////
   // Word buffer toward the cell array
   cssi_fifo #(
      .WIDTH(16),
      .DEPTH(8),
      .AW(3)
   ) u_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .clr(!config_start_n),
      .in_valid(push_q),
      .in_data(push_data_q),
      .in_ready(fifo_ready),
      .out_valid_q(cell_wvalid),
      .out_data_q(cell_wdata),
      .out_ready(cell_wready),
      .full(fifo_full)
   );

   ////////////////////////////////////////////////////////////////////////
   // Sequencer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_RESET;
         scheme_q <= 4'h0;
         volt_q <= 2'h0;
         is_ap_q <= 1'b0;
         fast_q <= 1'b0;
         fetched_q <= 24'h000000;
         wrote_q <= 24'h000000;
         flash_addr <= 24'h000000;
         push_q <= 1'b0;
         push_data_q <= 16'h0000;
         shift_q <= 8'h00;
         bits_q <= 4'h0;
         jtag_byte_ready <= 1'b0;
      end else if (!config_start_n) begin
         state_q <= ST_RESET;
         fetched_q <= 24'h000000;
         wrote_q <= 24'h000000;
         flash_addr <= 24'h000000;
         push_q <= 1'b0;
         bits_q <= 4'h0;
         jtag_byte_ready <= 1'b0;
         scheme_q <= sel_eff;
         is_ap_q <= dec_ap;
         fast_q <= dec_fast;
         volt_q <= dec_volt;
      end else begin
         push_q <= 1'b0;
         jtag_byte_ready <= 1'b0;
         // Count words the cell array has taken
         if (cell_wvalid && cell_wready)
            wrote_q <= wrote_q + 24'h000001;
         case (state_q)
            ST_RESET: begin
               state_q <= ST_DECODE;
            end
            ST_DECODE: begin
               state_q <= is_ap_q ? ST_LOAD : ST_UNSUP;
            end
            ST_LOAD: begin
               // Sample data on the falling edge, hold if buffer is full
               if (clk_fall && fifo_ready && !push_q) begin
                  push_q <= 1'b1;
                  push_data_q <= flash_data_in;
                  flash_addr <= flash_addr + 24'h000001;
                  fetched_q <= fetched_q + 24'h000001;
                  if (fetched_q + 24'h000001 >= words_q)
                     state_q <= ST_DRAIN;
               end
            end
            ST_DRAIN: begin
               // Done only once every fetched word reached the cells
               if (wrote_q == fetched_q)
                  state_q <= ST_USER;
            end
            ST_USER: begin
               if (ctrl_q[`CSSI_CTRL_BRIDGE])
                  state_q <= ST_BRIDGE;
            end
            ST_UNSUP: begin
               if (ctrl_q[`CSSI_CTRL_BRIDGE])
                  state_q <= ST_BRIDGE;
            end
            ST_BRIDGE: begin
               if (!bridge_live) begin
                  bits_q <= 4'h0;
                  if (!ctrl_q[`CSSI_CTRL_BRIDGE])
                     state_q <= is_ap_q ? ST_USER : ST_UNSUP;
               end else if (bits_q == 4'h0) begin
                  if (jtag_byte_valid && clk_fall) begin
                     shift_q <= jtag_byte;
                     bits_q <= 4'h8;
                     jtag_byte_ready <= 1'b1;
                  end
               end else if (clk_fall) begin
                  shift_q <= {shift_q[6:0], 1'b0};
                  bits_q <= bits_q - 4'h1;
               end
            end
            default: begin
               state_q <= ST_RESET;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin drivers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_select_out_n <= 1'b1;
         flash_select_oe <= 1'b0;
         serial_cmd_out <= 1'b0;
         serial_cmd_oe <= 1'b0;
         config_clock_oe <= 1'b0;
         flash_oe_n <= 1'b1;
         flash_bus_oe <= 1'b0;
         chain_enable_out_n <= 1'b1;
         config_done <= 1'b0;
         config_error <= 1'b0;
         fast_por <= 1'b0;
         remote_update_on <= 1'b0;
      end else begin
         flash_select_out_n <= !((state_q == ST_LOAD) || (bridge_live && bits_q != 4'h0));
         flash_select_oe <= (state_q == ST_LOAD) || bridge_live;
         serial_cmd_out <= shift_q[7];
         serial_cmd_oe <= bridge_live;
         config_clock_oe <= div_run;
         flash_oe_n <= (state_q != ST_LOAD);
         flash_bus_oe <= (state_q == ST_LOAD);
         chain_enable_out_n <= !(config_done && !chip_enable_in_n);
         config_done <= (state_q == ST_USER) || ((state_q == ST_BRIDGE) && is_ap_q);
         config_error <= (state_q == ST_UNSUP) || ((state_q == ST_BRIDGE) && !is_ap_q);
         fast_por <= is_ap_q && fast_q;
         remote_update_on <= is_ap_q && ctrl_q[`CSSI_CTRL_RUPD];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB slave, no wait states
   assign apb_wr = psel && penable && pready && pwrite;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         ctrl_q <= `CSSI_CTRL_RESET;
         words_q <= `CSSI_WORDS_RESET;
      end else begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         if (psel && !penable) begin
            prdata <= 32'h00000000;
            case (paddr)
               `CSSI_CTRL_OFF: begin
                  prdata <= ctrl_q & 32'h00000003;
               end
               `CSSI_STATUS_OFF: begin
                  prdata[`CSSI_ST_SCHEME_LSB +: 4] <= scheme_q;
                  prdata[`CSSI_ST_STATE_LSB +: 3] <= state_q;
                  prdata[`CSSI_ST_UNSUP] <= !is_ap_q;
                  prdata[`CSSI_ST_FASTPOR] <= fast_q;
                  prdata[`CSSI_ST_VOLT_LSB +: 2] <= volt_q;
                  prdata[`CSSI_ST_CE] <= chip_enable_in_n;
                  prdata[`CSSI_ST_FULL] <= fifo_full;
               end
               `CSSI_WORDS_OFF: begin
                  prdata <= {8'h00, words_q};
               end
               default: begin
                  pslverr <= 1'b1;
               end
            endcase
         end
         if (apb_wr) begin
            case (paddr)
               `CSSI_CTRL_OFF: begin
                  ctrl_q <= pwdata & 32'h00000003;
               end
               `CSSI_WORDS_OFF: begin
                  words_q <= pwdata[23:0];
               end
               default: begin
                  ctrl_q <= ctrl_q;
               end
            endcase
         end
      end
   end
endmodule // cssi_top
`default_nettype wire

// >>> tb/cssi_top_asserts.sv
// Port assertions for the scheme select and loader block.
// Assumes binding to cssi_top; pclk domain only.
`timescale 1ns/1ps
`default_nettype none
module cssi_top_asserts (
   input wire logic pclk, // Clock
   input wire logic presetn, // Reset
   input wire logic psel, // Select
   input wire logic penable, // Enable
   input wire logic pready, // Ready
   input wire logic [3:0] scheme_select, // Straps
   input wire logic config_start_n, // Start
   input wire logic chip_enable_in_n, // Cable
   input wire logic config_clock_out, // Clock out
   input wire logic serial_cmd_oe, // Data oe
   input wire logic flash_oe_n, // Flash oe
   input wire logic jtag_byte_ready, // Taken
   input wire logic cell_wvalid, // Cell valid
   input wire logic [15:0] cell_wdata, // Cell data
   input wire logic cell_wready, // Cell ready
   input wire logic config_done, // Done
   input wire logic config_error, // Error
   input wire logic fast_por, // Fast
   input wire logic remote_update_on // Update
);
   wire logic known = scheme_select inside {4'h5, 4'h6, 4'h7, 4'h8, 4'hB};
   wire logic fast = scheme_select inside {4'h5, 4'h6};
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_held;
      // Outputs are registered from the state: two cycles lag after entering reset
      !config_start_n [*3];
   endsequence
   sequence s_go;
      $rose(config_start_n);
   endsequence
   ////////////////////////////////////////
   chk_reset_idle: assert property (s_held |-> !config_done && !cell_wvalid && flash_oe_n)
      else $error("loader active in reset");
   chk_bad_code: assert property (s_go ##0 !known |-> ##[1:4] config_error)
      else $error("undefined code accepted");
   chk_good_code: assert property (s_go ##0 known |-> !config_error [*4])
      else $error("defined code refused");
   chk_fast_por: assert property (s_go ##0 fast |-> ##[1:4] fast_por)
      else $error("fast reset not chosen");
   chk_std_por: assert property (s_go ##0 known && !fast |-> !fast_por [*4])
      else $error("fast reset chosen wrongly");
   chk_unsup_idle: assert property (config_error |-> flash_oe_n && !cell_wvalid)
      else $error("loading with undefined code");
   chk_clock_rate: assert property ($rose(config_clock_out) |=> !config_clock_out [*2])
      else $error("flash clock too fast");
   chk_cell_hold: assert property (cell_wvalid && !cell_wready && config_start_n
      |=> cell_wvalid && $stable(cell_wdata))
      else $error("cell word dropped");
   chk_byte_pulse: assert property (jtag_byte_ready |=> !jtag_byte_ready)
      else $error("byte taken twice");
   chk_cable_owns: assert property (chip_enable_in_n [*2] |-> !serial_cmd_oe)
      else $error("serial data driven under cable");
   chk_update_ap: assert property (remote_update_on |-> !config_error)
      else $error("update on without parallel scheme");
   chk_apb_wait: assert property (psel && !penable |=> pready)
      else $error("apb answer late");
endmodule // cssi_top_asserts
bind cssi_top cssi_top_asserts chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pready(pready), .scheme_select(scheme_select), .config_start_n(config_start_n),
   .chip_enable_in_n(chip_enable_in_n), .config_clock_out(config_clock_out), .serial_cmd_oe(serial_cmd_oe),
   .flash_oe_n(flash_oe_n), .jtag_byte_ready(jtag_byte_ready), .cell_wvalid(cell_wvalid),
   .cell_wdata(cell_wdata), .cell_wready(cell_wready), .config_done(config_done),
   .config_error(config_error), .fast_por(fast_por), .remote_update_on(remote_update_on));
`default_nettype wire

// >>> tb/cssi_flash_model.sv
// Parallel flash model: word at each address is derived from it.
// Assumes flash_addr and enables from cssi_top.
`timescale 1ns/1ps
`default_nettype none
module cssi_flash_model (
   input wire logic pclk, // Clock
   input wire logic [23:0] flash_addr, // Address
   input wire logic flash_oe_n, // Read enable
   input wire logic flash_bus_oe, // Bus driven
   output logic [15:0] flash_data_in // Data
);
   logic [15:0] last_q = 16'h0000;
   wire logic drive = !flash_oe_n && flash_bus_oe;
   // Released bus shows a changing pattern
   assign flash_data_in = drive ? {flash_addr[7:0] ^ 8'h5A, flash_addr[7:0]} : ~last_q;
   always @(posedge pclk) begin
      last_q <= flash_data_in;
   end
endmodule // cssi_flash_model
`default_nettype wire

// >>> tb/cssi_top_tb.sv
// Testbench: decode, load, buffer, abort, bridge and registers.
// Assumes checker bound to cssi_top and flash model.
`timescale 1ns/1ps
`default_nettype none
module cssi_top_tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, stall = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, m, seed = 32'h3F;
   logic [3:0] scheme_select = 4'h0, code;
   logic config_start_n = 0, chip_enable_in_n = 0, chain_enable_out_n, config_clock_out, config_clock_oe;
   logic flash_select_out_n, flash_select_oe, serial_cmd_out, serial_cmd_oe, flash_oe_n, flash_bus_oe;
   logic jtag_byte_valid = 0, jtag_byte_ready, cell_wvalid, cell_wready = 0, ck_prev = 0, good, fp;
   logic config_done, config_error, fast_por, remote_update_on;
   logic [23:0] flash_addr, fa;
   logic [15:0] flash_data_in, cell_wdata;
   logic [7:0] jtag_byte = 8'h00, sr = 8'h00, b;
   logic [3:0] codes [8] = '{4'h5, 4'h6, 4'h7, 4'h8, 4'hB, 4'h0, 4'h4, 4'hF};
   logic [1:0] volts [5] = '{2'h0, 2'h1, 2'h0, 2'h1, 2'h2};
   logic [32:0] rd_q[$];
   logic [31:0] mk_q[$];
   logic [15:0] cw_q[$];
   int fail_count = 0, tests_run = 0;
   cssi_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .scheme_select(scheme_select), .config_start_n(config_start_n), .chip_enable_in_n(chip_enable_in_n),
      .chain_enable_out_n(chain_enable_out_n), .config_clock_out(config_clock_out),
      .config_clock_oe(config_clock_oe), .flash_select_out_n(flash_select_out_n),
      .flash_select_oe(flash_select_oe), .serial_cmd_out(serial_cmd_out), .serial_cmd_oe(serial_cmd_oe),
      .flash_addr(flash_addr), .flash_oe_n(flash_oe_n), .flash_bus_oe(flash_bus_oe),
      .flash_data_in(flash_data_in), .jtag_byte_valid(jtag_byte_valid), .jtag_byte(jtag_byte),
      .jtag_byte_ready(jtag_byte_ready), .cell_wvalid(cell_wvalid), .cell_wdata(cell_wdata),
      .cell_wready(cell_wready), .config_done(config_done), .config_error(config_error),
      .fast_por(fast_por), .remote_update_on(remote_update_on));
   cssi_flash_model flash_u (.pclk(pclk), .flash_addr(flash_addr), .flash_oe_n(flash_oe_n),
      .flash_bus_oe(flash_bus_oe), .flash_data_in(flash_data_in));
   always #5 pclk = ~pclk;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [15:0] word(input int a);
      return {a[7:0] ^ 8'h5A, a[7:0]};
   endfunction
   task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic wait_for(ref logic s, input logic v, input int lim);
      int n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (s !== v && n < lim);
      if (s !== v) chk("wait", 0, 1);
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      wait_for(pready, 1, 50);
      psel <= 0;
      penable <= 0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [32:0] e, input logic [31:0] mk);
      rd_q.push_back(e);
      mk_q.push_back(mk);
      apb(0, a, 32'h0);
   endtask
   ////////////////////////////////////////
   // Watches reads, cell words and serial bits
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && rd_q.size() > 0) begin
         m = mk_q.pop_front();
         chk("apb read", rd_q.pop_front(), {pslverr, prdata & m});
      end
      if (cell_wvalid === 1'b1 && cell_wready)
         chk("cell word", cw_q.size() ? cw_q.pop_front() : 16'hDEAD, cell_wdata);
      if (config_clock_out && !ck_prev && !flash_select_out_n)
         sr <= {sr[6:0], serial_cmd_out};
      ck_prev <= config_clock_out;
      cell_wready <= !stall && rnd() % 4 != 0;
   end
   initial begin
      #300000;
      chk("watchdog", 0, 1);
      summarize();
   end
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1;
      rd(12'h000, 33'h0, 32'hFFFFFFFF);
      rd(12'h008, 33'h100, 32'hFFFFFFFF);
      rd(12'h00C, 33'h100000000, 32'hFFFFFFFF);
      apb(1, 12'h008, 32'h0000000C);
      apb(1, 12'h00C, 32'hFFFFFFFF);
      apb(1, 12'h004, 32'hFFFFFFFF);
      rd(12'h008, 33'hC, 32'hFFFFFFFF);
      $display("test registers done");
      for (int i = 0; i < 8; i++) begin
         code = codes[i];
         good = i < 5;
         fp = i < 2;
         apb(1, 12'h000, i % 2);
         @(posedge pclk);
         config_start_n <= 0;
         scheme_select <= code;
         stall <= i == 1;
         repeat (3) @(posedge pclk);
         if (good) for (int k = 0; k < 12; k++) cw_q.push_back(word(k));
         config_start_n <= 1;
         repeat (4) @(posedge pclk);
         rd(12'h004, {good ? volts[i] : 2'h0, fp, !good, 3'h0, code}, good ? 32'h78F : 32'h8F);
         chk("fast_por", fp, fast_por);
         chk("remote_update_on", good && i % 2, remote_update_on);
         if (good) begin
            if (i == 0) begin
               repeat (15) @(posedge pclk);
               config_start_n <= 0;
               repeat (3) @(posedge pclk);
               cw_q.delete();
               chk("abort", 0, {config_done, cell_wvalid});
               for (int k = 0; k < 12; k++) cw_q.push_back(word(k));
               config_start_n <= 1;
            end
            if (i == 1) begin
               repeat (60) @(posedge pclk);
               rd(12'h004, 33'h1000, 32'h1000);
               fa = flash_addr;
               repeat (6) @(posedge pclk);
               chk("address hold", fa, flash_addr);
               chk("master drive", 3'b110, {flash_bus_oe, config_clock_oe, flash_oe_n});
               stall <= 0;
            end
            wait_for(config_done, 1, 3000);
            repeat (4) @(posedge pclk);
            chk("words left", 0, cw_q.size());
            chk("chain out", 0, chain_enable_out_n);
         end
         $display("test scheme %h done", code);
      end
      apb(1, 12'h000, 32'h2);
      for (int j = 0; j < 3; j++) begin
         b = rnd();
         @(posedge pclk);
         jtag_byte_valid <= 1;
         jtag_byte <= b;
         wait_for(jtag_byte_ready, 1, 100);
         jtag_byte_valid <= 0;
         wait_for(flash_select_out_n, 1, 100);
         chk("serial byte", b, sr);
      end
      chip_enable_in_n <= 1;
      config_start_n <= 0;
      repeat (4) @(posedge pclk);
      chk("cable owns", 1, {serial_cmd_oe, flash_select_oe, config_clock_oe, chain_enable_out_n});
      chip_enable_in_n <= 0;
      config_start_n <= 1;
      $display("test bridge done");
      summarize();
   end
endmodule // cssi_top_tb
`default_nettype wire
